/* File: common/vdrm_defs.vh */
// Constants for the range mask monitor: register map, field positions,
// thresholds and control-bit source codes.
// Assumes a 14-bit sample path clocked once per sample by ref_clk.
//
// What this block does
// - Enabled monitor keeps up to 14 bits in band, never under 9 bits.
// - Samples are never scaled; only their resolution changes.
// - Enable and configuration held per channel, writable through the control port.
// - Complex mode offers 25% or 43% bandwidth; real mode offers 25% only.
// - Mode and bandwidth come from register 0x430; zones follow that choice.
// - Reduction follows the peak combined level inside the forbidden zones.
// - No reduction at or below -30 dBFS; reduce once above it.
// - One bit lost per 6 dB above -30 dBFS, down to 9 bits.
// - Registers 0x559 and 0x55a place status bits into per-sample control bits.
// - Reduced-resolution flag goes on any position; 1 while reducing, else 0.
// - Indicator 00=14, 01=13, 10=12 or 11, 11=10 or 9 bits.
// - Band center set by bits 3:0 of 0x434 in sixteenths of sample rate.
// - Complex mode accepts all tuning words 0x0 to 0xf.
// - 25% modes allow one eighth of sample rate each side of center.
// - 43% complex mode allows about 43% of sample rate around center.
// - Control bits fill from position 2 downward.
`ifndef VDRM_DEFS_VH
`define VDRM_DEFS_VH

`define VDRM_ADDR_MODE     12'h430
`define VDRM_ADDR_TUNE     12'h434
`define VDRM_ADDR_STAT     12'h438
`define VDRM_ADDR_CBA      12'h559
`define VDRM_ADDR_CBB      12'h55a

`define VDRM_REG_RST       8'h00

`define VDRM_MODE_EN       0
`define VDRM_MODE_CPLX     1
`define VDRM_MODE_BW43     2

`define VDRM_SRC_POS0_LO   1
`define VDRM_SRC_POS0_HI   0
`define VDRM_SRC_POS1_LO   5
`define VDRM_SRC_POS1_HI   4
`define VDRM_SRC_POS2_LO   1
`define VDRM_SRC_POS2_HI   0
`define VDRM_CS_HI         5
`define VDRM_CS_LO         4

`define VDRM_SRC_ZERO      2'h0
`define VDRM_SRC_PUN0      2'h1
`define VDRM_SRC_PUN1      2'h2
`define VDRM_SRC_FLAG      2'h3

`define VDRM_THR_30        18'h00103
`define VDRM_THR_24        18'h00205
`define VDRM_THR_18        18'h00408
`define VDRM_THR_12        18'h0080a
`define VDRM_THR_6         18'h0100a
`define VDRM_DECAY_SHIFT   6

`define VDRM_SAMPLE_W      14
`define VDRM_CHANNELS      4

`endif

/* File: core/vdrm_zone_level.v */
// Forbidden-zone level estimator for one channel: mixes the tuned band
// center to zero, removes the allowed band and peak-tracks the remainder.
// Assumes one sample per ref_clk, inputs synchronous to ref_clk.
`timescale 1ns/1ps
`include "vdrm_defs.vh"

module vdrm_zone_level (
	input  wire               ref_clk,
	input  wire               rst,
	input  wire signed [13:0] i_in,
	input  wire signed [13:0] q_in,
	input  wire               enable,
	input  wire               bw43,
	input  wire        [3:0]  tune,
	output reg         [2:0]  cut_reg
);

	function signed [8:0] cos16;
		input [3:0] p;
		begin
			case (p)
			4'h0: cos16 = 9'sd255;
			4'h1: cos16 = 9'sd236;
			4'h2: cos16 = 9'sd180;
			4'h3: cos16 = 9'sd98;
			4'h4: cos16 = 9'sd0;
			4'h5: cos16 = -9'sd98;
			4'h6: cos16 = -9'sd180;
			4'h7: cos16 = -9'sd236;
			4'h8: cos16 = -9'sd255;
			4'h9: cos16 = -9'sd236;
			4'ha: cos16 = -9'sd180;
			4'hb: cos16 = -9'sd98;
			4'hc: cos16 = 9'sd0;
			4'hd: cos16 = 9'sd98;
			4'he: cos16 = 9'sd180;
			default: cos16 = 9'sd236;
			endcase
		end
	endfunction

	function [17:0] absv;
		input signed [17:0] v;
		begin
			absv = v[17] ? (~v + 18'h00001) : v;
		end
	endfunction

	reg         [3:0]  phase_reg;
	reg  signed [15:0] re_d1_reg;
	reg  signed [15:0] re_d2_reg;
	reg  signed [15:0] re_d3_reg;
	reg  signed [15:0] im_d1_reg;
	reg  signed [15:0] im_d2_reg;
	reg  signed [15:0] im_d3_reg;
	reg         [17:0] peak_reg;
	reg         [17:0] peak_next;
	reg         [2:0]  cut_next;

	wire signed [8:0]  c_w = cos16(phase_reg);
	wire signed [8:0]  s_w = cos16(phase_reg - 4'h4);
	// Rotate by the negative band center so the allowed band sits at zero
	wire signed [23:0] re_full = i_in * c_w + q_in * s_w;
	wire signed [23:0] im_full = q_in * c_w - i_in * s_w;
	wire signed [15:0] re_w = re_full[23:8];
	wire signed [15:0] im_w = im_full[23:8];

	wire signed [17:0] re_sum4 = re_w + re_d1_reg + re_d2_reg + re_d3_reg;
	wire signed [17:0] im_sum4 = im_w + im_d1_reg + im_d2_reg + im_d3_reg;
	wire signed [17:0] re_sum2 = re_w + re_d1_reg;
	wire signed [17:0] im_sum2 = im_w + im_d1_reg;
	// Four-tap average passes +-fs/8, two-tap the wider band
	wire signed [17:0] re_avg = bw43 ? (re_sum2 >>> 1) : (re_sum4 >>> 2);
	wire signed [17:0] im_avg = bw43 ? (im_sum2 >>> 1) : (im_sum4 >>> 2);
	wire signed [17:0] re_res = {{2{re_w[15]}}, re_w} - re_avg;
	wire signed [17:0] im_res = {{2{im_w[15]}}, im_w} - im_avg;
	wire        [17:0] re_mag = absv(re_res);
	wire        [17:0] im_mag = absv(im_res);
	// Cheap magnitude, within about 12% of the true modulus
	wire        [17:0] mag = (re_mag > im_mag) ? (re_mag + (im_mag >> 1))
	                                           : (im_mag + (re_mag >> 1));

	always @* begin
		// Peak hold with slow decay so short bursts still count
		if (mag > peak_reg) begin
			peak_next = mag;
		end else begin
			peak_next = peak_reg - (peak_reg >> `VDRM_DECAY_SHIFT);
		end
		// One more bit cut per 6 dB step above the limit
		cut_next = {2'h0, peak_reg > `VDRM_THR_30} + {2'h0, peak_reg > `VDRM_THR_24}
		         + {2'h0, peak_reg > `VDRM_THR_18} + {2'h0, peak_reg > `VDRM_THR_12}
		         + {2'h0, peak_reg > `VDRM_THR_6};
		if (!enable) begin
			cut_next = 3'h0;
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			phase_reg <= 4'h0;
			re_d1_reg <= 16'h0000;
			re_d2_reg <= 16'h0000;
			re_d3_reg <= 16'h0000;
			im_d1_reg <= 16'h0000;
			im_d2_reg <= 16'h0000;
			im_d3_reg <= 16'h0000;
			peak_reg  <= 18'h00000;
			cut_reg   <= 3'h0;
		end else begin
			phase_reg <= phase_reg + tune;
			re_d1_reg <= re_w;
			re_d2_reg <= re_d1_reg;
			re_d3_reg <= re_d2_reg;
			im_d1_reg <= im_w;
			im_d2_reg <= im_d1_reg;
			im_d3_reg <= im_d2_reg;
			peak_reg  <= enable ? peak_next : 18'h00000;
			cut_reg   <= cut_next;
		end
	end

endmodule

/* File: core/vdrm_monitor.v */
// Four-channel range mask monitor: per-channel configuration registers,
// resolution cut of output samples and per-sample control bits.
// Assumes one sample per channel per ref_clk and a register port that
// carries decoded control-port writes and reads.
`timescale 1ns/1ps
`include "vdrm_defs.vh"

module vdrm_monitor (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [55:0] smp_in,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [11:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire [3:0]  reg_chan_mask,
	input  wire [1:0]  reg_rd_chan,
	output reg  [7:0]  reg_rdata,
	output reg  [55:0] smp_out,
	output reg  [11:0] ctrl_out
);

	reg  [7:0]  mode_reg [0:3];
	reg  [7:0]  tune_reg [0:3];
	reg  [7:0]  cba_reg  [0:3];
	reg  [7:0]  cbb_reg  [0:3];
	wire [11:0] cut_all;
	wire [3:0]  flag_all;
	wire [7:0]  pun_all;
	reg  [7:0]  rdata_next;
	reg  [2:0]  rd_cut;
	wire [55:0] smp_all;
	wire [11:0] ctrl_all;
	integer     j;

	genvar g;
	generate
		for (g = 0; g < `VDRM_CHANNELS; g = g + 1) begin : ch
			localparam integer PI = (g / 2) * 2;
			wire        cplx = mode_reg[g][`VDRM_MODE_CPLX];
			// Real mode forces the narrow band
			wire        wide = cplx & mode_reg[g][`VDRM_MODE_BW43];
			// First channel of a pair is I, second is Q
			wire [13:0] i_sel = cplx ? smp_in[PI*14 +: 14] : smp_in[g*14 +: 14];
			wire [13:0] q_sel = cplx ? smp_in[(PI+1)*14 +: 14] : 14'h0000;
			wire [2:0]  cut;
			wire [1:0]  pun;
			wire        flag;
			wire [13:0] keep;
			wire [13:0] smp;
			wire [2:0]  bits_w;
			wire [1:0]  cs;
			reg  [2:0]  ctrl;

			vdrm_zone_level u_zone (
				.ref_clk (ref_clk),
				.rst     (rst),
				.i_in    (i_sel),
				.q_in    (q_sel),
				.enable  (mode_reg[g][`VDRM_MODE_EN]),
				.bw43    (wide),
				.tune    (tune_reg[g][3:0]),
				.cut_reg (cut)
			);

			// Indicator encoding of the current resolution
			assign pun  = (cut == 3'h0) ? 2'h0 :
			              (cut == 3'h1) ? 2'h1 :
			              (cut <= 3'h3) ? 2'h2 : 2'h3;
			assign flag = (cut != 3'h0);
			// Low bits masked, never shifted or scaled
			assign keep = ~((14'h0001 << cut) - 14'h0001);
			assign smp  = smp_in[g*14 +: 14] & keep;
			assign bits_w = {flag, pun};
			assign cs   = cbb_reg[g][`VDRM_CS_HI:`VDRM_CS_LO];
			assign cut_all[g*3 +: 3] = cut;
			assign flag_all[g] = flag;
			assign pun_all[g*2 +: 2] = pun;

			function sel;
				input [1:0] src;
				input [2:0] b;
				begin
					case (src)
					`VDRM_SRC_PUN0: sel = b[0];
					`VDRM_SRC_PUN1: sel = b[1];
					`VDRM_SRC_FLAG: sel = b[2];
					default:        sel = 1'b0;
					endcase
				end
			endfunction

			always @* begin
				// Status bits placed as chosen in the two select registers
				ctrl[0] = sel(cba_reg[g][`VDRM_SRC_POS0_LO:`VDRM_SRC_POS0_HI], bits_w);
				ctrl[1] = sel(cba_reg[g][`VDRM_SRC_POS1_LO:`VDRM_SRC_POS1_HI], bits_w);
				ctrl[2] = sel(cbb_reg[g][`VDRM_SRC_POS2_LO:`VDRM_SRC_POS2_HI], bits_w);
				// Positions fill from the top; unused ones stay zero
				if (cs < 2'h3) begin
					ctrl[0] = 1'b0;
				end
				if (cs < 2'h2) begin
					ctrl[1] = 1'b0;
				end
				if (cs < 2'h1) begin
					ctrl[2] = 1'b0;
				end
			end

			assign smp_all[g*14 +: 14] = smp;
			assign ctrl_all[g*3 +: 3]  = ctrl;
		end
	endgenerate

	// One process owns every config array, smp_out and ctrl_out, so none of them has two drivers
	always @(posedge ref_clk) begin
		if (rst) begin
			for (j = 0; j < `VDRM_CHANNELS; j = j + 1) begin
				mode_reg[j] <= `VDRM_REG_RST;
				tune_reg[j] <= `VDRM_REG_RST;
				cba_reg[j]  <= `VDRM_REG_RST;
				cbb_reg[j]  <= `VDRM_REG_RST;
			end
			smp_out  <= 56'h00000000000000;
			ctrl_out <= 12'h000;
		end else begin
			for (j = 0; j < `VDRM_CHANNELS; j = j + 1) begin
				// Each channel keeps its own copy; the mask picks targets
				if (reg_wr && reg_chan_mask[j]) begin
					case (reg_addr)
					`VDRM_ADDR_MODE: mode_reg[j] <= reg_wdata;
					`VDRM_ADDR_TUNE: tune_reg[j] <= reg_wdata;
					`VDRM_ADDR_CBA:  cba_reg[j]  <= reg_wdata;
					`VDRM_ADDR_CBB:  cbb_reg[j]  <= reg_wdata;
					default: ;
					endcase
				end
			end
			smp_out  <= smp_all;
			ctrl_out <= ctrl_all;
		end
	end

	always @* begin
		rd_cut = cut_all[reg_rd_chan*3 +: 3];
		case (reg_addr)
		`VDRM_ADDR_MODE: rdata_next = mode_reg[reg_rd_chan];
		`VDRM_ADDR_TUNE: rdata_next = tune_reg[reg_rd_chan];
		`VDRM_ADDR_CBA:  rdata_next = cba_reg[reg_rd_chan];
		`VDRM_ADDR_CBB:  rdata_next = cbb_reg[reg_rd_chan];
		// Live status: flag, indicator and number of bits cut
		`VDRM_ADDR_STAT: rdata_next = {1'b0, flag_all[reg_rd_chan],
		                               pun_all[reg_rd_chan*2 +: 2], 1'b0, rd_cut};
		default:         rdata_next = 8'h00;
		endcase
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end
	end

endmodule

/* File: sim/vdrm_checker.sv */
// Port checker for the range mask monitor.
// Assumes bind to vdrm_monitor, one sample per ref_clk.
`timescale 1ns/1ps
`include "vdrm_defs.vh"
module vdrm_checker (
	input wire        ref_clk,
	input wire        rst,
	input wire [55:0] smp_in,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [11:0] reg_addr,
	input wire [7:0]  reg_wdata,
	input wire [3:0]  reg_chan_mask,
	input wire [1:0]  reg_rd_chan,
	input wire [7:0]  reg_rdata,
	input wire [55:0] smp_out,
	input wire [11:0] ctrl_out
);
	localparam [55:0] KEEP = {4{14'h3fe0}};
	reg       en0_reg;
	reg       cbw_reg;
	reg [2:0] dis_reg;
	wire      mapped = reg_addr == `VDRM_ADDR_MODE || reg_addr == `VDRM_ADDR_TUNE ||
		reg_addr == `VDRM_ADDR_STAT || reg_addr == `VDRM_ADDR_CBA || reg_addr == `VDRM_ADDR_CBB;
	// Each channel must be its input with 0..5 low bits cleared
	function automatic logic cut_ok(input logic [55:0] i, input logic [55:0] o);
		integer g;
		integer k;
		logic   hit;
		cut_ok = 1'b1;
		for (g = 0; g < 4; g = g + 1) begin
			hit = 1'b0;
			for (k = 0; k < 6; k = k + 1)
				hit = hit | (o[14*g+:14] == (i[14*g+:14] & (14'h3fff << k)));
			cut_ok = cut_ok & hit;
		end
	endfunction
	always @(posedge ref_clk) begin
		if (rst) begin
			en0_reg <= 1'b0;
			cbw_reg <= 1'b0;
			dis_reg <= 3'h0;
		end else begin
			if (reg_wr && reg_chan_mask[0] && reg_addr == `VDRM_ADDR_MODE)
				en0_reg <= reg_wdata[0];
			if (reg_wr && reg_addr == `VDRM_ADDR_CBB)
				cbw_reg <= 1'b1;
			dis_reg <= en0_reg ? 3'h0 : (dis_reg == 3'h7 ? dis_reg : dis_reg + 3'h1);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_tune_wr;
		reg_wr && reg_chan_mask[0] && reg_addr == `VDRM_ADDR_TUNE;
	endsequence
	sequence s_tune_rd;
		reg_rd && !reg_wr && reg_rd_chan == 2'h0 && reg_addr == `VDRM_ADDR_TUNE;
	endsequence
	a_reset_clears: assert property ($fell(rst) |-> smp_out == 56'h0 &&
		ctrl_out == 12'h0 && reg_rdata == 8'h0) else $error("outputs not cleared");
	a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	a_tune_readback: assert property (s_tune_wr ##1 s_tune_rd |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("tune readback wrong");
	a_min_res: assert property (!$past(rst) |->
		((smp_out ^ $past(smp_in)) & KEEP) == 56'h0) else $error("top bits changed");
	a_cut_shape: assert property (!$past(rst) |-> cut_ok($past(smp_in), smp_out))
		else $error("sample not a clean cut");
	a_disabled_pass: assert property (!en0_reg && dis_reg == 3'h7 |->
		smp_out[13:0] == $past(smp_in[13:0]) && ctrl_out[2:0] == 3'h0)
		else $error("disabled channel altered");
	a_ctrl_idle: assert property (!cbw_reg |-> ctrl_out == 12'h0)
		else $error("control bits without select");
endmodule
bind vdrm_monitor vdrm_checker u_chk (.ref_clk, .rst, .smp_in, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_chan_mask, .reg_rd_chan, .reg_rdata, .smp_out, .ctrl_out);

/* File: sim/vdrm_link_rx.sv */
// Far-end link receiver model: joins channel 0 sample and its control bits.
// Assumes one sample per ref_clk, control bits already in transport order.
`timescale 1ns/1ps
module vdrm_link_rx (
	input  wire        ref_clk,
	input  wire [55:0] smp_out,
	input  wire [11:0] ctrl_out,
	output reg  [16:0] word0
);
	// Control bits ride below the sample, position 2 first
	always @(posedge ref_clk)
		word0 <= {smp_out[13:0], ctrl_out[2:0]};
endmodule

/* File: sim/variable_dynamic_range_monitor_tb.sv */
// Bench for the range mask monitor: register tasks, tone ladder, link model.
// Assumes vdrm_monitor, vdrm_link_rx and the checker are compiled first.
`timescale 1ns/1ps
`include "vdrm_defs.vh"
module variable_dynamic_range_monitor_tb;
	localparam [83:0] LAD = {14'h1770, 14'h0b54, 14'h05aa, 14'h02da, 14'h0168, 14'h00c8};
	reg         ref_clk = 1'b0;
	reg         rst = 1'b1;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg         ph = 1'b0;
	reg         dc = 1'b0;
	reg  [55:0] smp_in = 56'h0;
	reg  [55:0] prev_in = 56'h0;
	reg  [11:0] reg_addr = 12'h0;
	reg  [7:0]  reg_wdata = 8'h0;
	reg  [3:0]  reg_chan_mask = 4'h0;
	reg  [1:0]  reg_rd_chan = 2'h0;
	reg  [13:0] amp = 14'h0;
	wire [13:0] s = (ph && !dc) ? -amp : amp;
	wire [7:0]  reg_rdata;
	wire [55:0] smp_out;
	wire [11:0] ctrl_out;
	wire [16:0] word0;
	integer     num_errors = 0;
	integer     n_tests = 0;
	integer     cyc = 0;
	integer     i;
	always #10 ref_clk = ~ref_clk;
	vdrm_monitor dut (.ref_clk, .rst, .smp_in, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_chan_mask, .reg_rd_chan, .reg_rdata, .smp_out, .ctrl_out);
	vdrm_link_rx u_rx (.ref_clk, .smp_out, .ctrl_out, .word0);
	// Q channel held at zero so the pair sees a pure I tone
	always @(posedge ref_clk) begin
		ph <= ~ph;
		prev_in <= smp_in;
		smp_in <= #1 {14'h0, s, 14'h0, s};
		cyc = cyc + 1;
		if (cyc == 6000) begin
			num_errors = num_errors + 1;
			conclude;
		end
	end
	task conclude;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input [15:0] seen, input [15:0] exp, input string name);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("wrong value %0s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Entered one step after an edge; back-to-back calls land on adjacent edges
	// Strobe is left high; the next rd, step or explicit clear lowers it, a following wr keeps it high, never in the same step
	task wr(input [11:0] a, input [7:0] d, input [3:0] msk);
		reg_rd = 1'b0;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		reg_chan_mask = msk;
		@(posedge ref_clk) #1;
	endtask
	task rd(input [11:0] a, input [1:0] c, input [7:0] e);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		reg_addr = a;
		reg_rd_chan = c;
		@(posedge ref_clk) #1;
		chk(reg_rdata, e, "rdata");
	endtask
	// Long settle: the peak tracker decays slowly after a loud tone
	task step(input [2:0] k);
		reg [1:0] ind;
		ind = (k == 0) ? 2'h0 : (k == 1) ? 2'h1 : (k < 4) ? 2'h2 : 2'h3;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (300) @(posedge ref_clk);
		#1;
		chk(smp_out[13:0], prev_in[13:0] & (14'h3fff << k), "cut");
		chk(smp_out[41:28], prev_in[41:28], "ch2");
		chk(word0[2:0], {k != 0, ind}, "ctrl");
		rd(`VDRM_ADDR_STAT, 2'h0, {1'b0, k != 0, ind, 1'b0, k});
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		rd(`VDRM_ADDR_MODE, 2'h0, 8'h00);
		wr(`VDRM_ADDR_TUNE, 8'h0f, 4'h1);
		rd(`VDRM_ADDR_TUNE, 2'h0, 8'h0f);
		rd(12'h123, 2'h0, 8'h00);
		wr(`VDRM_ADDR_TUNE, 8'h00, 4'h1);
		wr(`VDRM_ADDR_MODE, 8'h03, 4'h1);
		rd(`VDRM_ADDR_MODE, 2'h2, 8'h00);
		wr(`VDRM_ADDR_CBA, 8'h21, 4'h1);
		wr(`VDRM_ADDR_CBB, 8'h33, 4'h1);
		for (i = 0; i < 6; i = i + 1) begin
			amp = LAD[14*i+:14];
			step(i[2:0]);
		end
		wr(`VDRM_ADDR_CBB, 8'h13, 4'h1);
		reg_wr = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(word0[2:0], 16'h4, "cs1");
		dc = 1'b1;
		step(3'h0);
		wr(`VDRM_ADDR_TUNE, 8'h08, 4'h1);
		dc = 1'b0;
		step(3'h0);
		wr(`VDRM_ADDR_CBB, 8'h33, 4'h1);
		wr(`VDRM_ADDR_TUNE, 8'h00, 4'h1);
		wr(`VDRM_ADDR_MODE, 8'h07, 4'h1);
		step(3'h5);
		dc = 1'b1;
		step(3'h0);
		wr(`VDRM_ADDR_MODE, 8'h00, 4'h1);
		step(3'h0);
		dc = 1'b0;
		// Real mode on the second pair: strong tone outside the tuned band
		wr(`VDRM_ADDR_TUNE, 8'h04, 4'h4);
		wr(`VDRM_ADDR_MODE, 8'h05, 4'h4);
		reg_wr = 1'b0;
		repeat (300) @(posedge ref_clk);
		#1;
		chk(smp_out[41:28], prev_in[41:28] & 14'h3fe0, "real");
		rd(`VDRM_ADDR_STAT, 2'h2, 8'h75);
		conclude;
	end
endmodule
